// file: design/shadow_pkg.sv
// Constants shared by the serial port shadow control block and its queue.
package shadow_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_DATA = 32'h50001100;
  localparam logic [31:0] ADDR_QUEUE_CTL = 32'h50001108;
  localparam logic [31:0] ADDR_LINE_CTL = 32'h5000110c;
  localparam logic [31:0] ADDR_MODEM_CTL = 32'h50001110;
  localparam logic [31:0] ADDR_STATUS = 32'h50001114;
  localparam logic [31:0] ADDR_BREAK_ALIAS = 32'h50001190;
  localparam logic [31:0] ADDR_DMA_ALIAS = 32'h50001194;
  localparam logic [31:0] ADDR_QEN_ALIAS = 32'h50001198;
  localparam logic [31:0] ADDR_RXTRIG_ALIAS = 32'h5000119c;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BRK_BIT = 6;
  localparam int LOOP_BIT = 4;
  localparam int IR_BIT = 6;
  localparam int QEN_BIT = 0;
  localparam int RXF_BIT = 1;
  localparam int TXF_BIT = 2;
  localparam int DMA_BIT = 3;
  localparam int ST_TXFULL = 0;
  localparam int ST_TXEMPTY = 1;
  localparam int ST_RXAVAIL = 2;
  localparam int ST_BREAK = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_LINE = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] BRK_MASK = 8'h40;
  localparam logic [7:0] QEN_MASK = 8'h01;
  localparam logic [7:0] DMA_MASK = 8'h08;
  localparam logic [7:0] FLUSH_MASK = 8'h06;

  // ----------------------------------------------------------------------
  // Datapath sizes and timing counts
  // ----------------------------------------------------------------------
  localparam int CHAR_W = 8;
  localparam int QUEUE_DEPTH = 8;
  localparam int BIT_CYCLES_DEF = 16;
  localparam int IR_PULSE_DEF = 3;
  localparam int RX_BURST_DEF = 4;

endpackage : shadow_pkg

// file: design/queue_buffer.sv
// Flip-flop FIFO with valid/ready on both sides and a pointer flush.
`timescale 1ns/1ps
module queue_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Handshakes; full and empty come from the occupancy count.
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rptr_r];
  assign level = cnt_r;

  // Pointers and count; a flush empties the queue, storage is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage is written only; it is not cleared by reset or flush.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

endmodule : queue_buffer

// file: design/uart_shadow_control.sv
// Serial port with break, DMA mode and queue enable shadow aliases.
`timescale 1ns/1ps
module uart_shadow_control
  import shadow_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF,
  parameter int IR_PULSE = IR_PULSE_DEF,
  parameter int RX_BURST = RX_BURST_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sin,
  output logic sout,
  output logic sir_out_n,
  output logic dma_tx_req_n,
  output logic dma_rx_req_n
);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam int LW = $clog2(QUEUE_DEPTH) + 1;

  typedef enum logic [1:0] {idle_s, start_s, data_s, stop_s} ser_type;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction : hit

  logic [7:0] line_control_r, line_control_nxt;
  logic [7:0] modem_control_r, modem_control_nxt;
  logic [7:0] queue_control_r, queue_control_nxt;
  logic break_seen_r, overrun_r;
  logic [31:0] prdata_r, rd_val;
  logic pready_r, pslverr_r;
  logic wr_done, rd_done, rd_cap;
  logic h_data, h_qctl, h_line, h_modem, h_stat;
  logic h_brk, h_dma, h_qen, h_rtrig, h_any;
  logic brk, loop, ir, qen, dma_mode;
  logic tx_flush, rx_flush, qen_fall;
  logic tx_in_ready, tx_in_ok, tx_valid, tx_pop, tx_empty;
  logic rx_in_ready, rx_in_ok, rx_valid, rx_push;
  logic [CHAR_W-1:0] tx_data, rx_data;
  logic [LW-1:0] tx_level, rx_level;
  logic [7:0] status;
  logic [CHAR_W-1:0] rx_shift_r;
  logic rx_line, samp, rx_brk_evt;

  // Address decode and transfer phases; the access phase takes two cycles.
  assign h_data = hit(paddr, ADDR_DATA);
  assign h_qctl = hit(paddr, ADDR_QUEUE_CTL);
  assign h_line = hit(paddr, ADDR_LINE_CTL);
  assign h_modem = hit(paddr, ADDR_MODEM_CTL);
  assign h_stat = hit(paddr, ADDR_STATUS);
  assign h_brk = hit(paddr, ADDR_BREAK_ALIAS);
  assign h_dma = hit(paddr, ADDR_DMA_ALIAS);
  assign h_qen = hit(paddr, ADDR_QEN_ALIAS);
  assign h_rtrig = hit(paddr, ADDR_RXTRIG_ALIAS);
  assign h_any = h_data | h_qctl | h_line | h_modem | h_stat | h_brk
               | h_dma | h_qen | h_rtrig;
  assign rd_cap = psel & penable & ~pready_r;
  assign wr_done = psel & penable & pready_r & pwrite & h_any;
  assign rd_done = psel & penable & pready_r & ~pwrite;

  // Mode bits taken from the shared control storage.
  assign brk = line_control_r[BRK_BIT];
  assign loop = modem_control_r[LOOP_BIT];
  assign ir = modem_control_r[IR_BIT];
  assign qen = queue_control_r[QEN_BIT];
  assign dma_mode = queue_control_r[DMA_BIT];

  // Control writes; the break, DMA and enable aliases each write one bit of the shared storage only.
  assign line_control_nxt =
    (wr_done & h_line) ? pwdata[7:0] :
    (wr_done & h_brk) ? ((line_control_r & ~BRK_MASK) |
                         ({8{pwdata[0]}} & BRK_MASK)) :
    line_control_r;
  assign modem_control_nxt = (wr_done & h_modem) ? pwdata[7:0]
                                                 : modem_control_r;
  assign queue_control_nxt =
    (wr_done & h_qctl) ? (pwdata[7:0] & ~FLUSH_MASK) :
    (wr_done & h_dma) ? ((queue_control_r & ~DMA_MASK) |
                         ({8{pwdata[0]}} & DMA_MASK)) :
    (wr_done & h_qen) ? ((queue_control_r & ~QEN_MASK) |
                         ({8{pwdata[0]}} & QEN_MASK)) :
    queue_control_r;

  // Queue resets: enable falling, or the self-clearing flush bits.
  assign qen_fall = queue_control_r[QEN_BIT] & ~queue_control_nxt[QEN_BIT];
  assign tx_flush = qen_fall |
                    (wr_done & h_qctl & pwdata[TXF_BIT]);
  assign rx_flush = qen_fall |
                    (wr_done & h_qctl & pwdata[RXF_BIT]);

  // Read data; alias upper bits and the trigger alias read as zero.
  assign status = {2'b00, rx_line, overrun_r, break_seen_r, rx_valid,
                   tx_empty, ~tx_in_ready};
  assign rd_val =
    h_data ? {{(32-CHAR_W){1'b0}}, rx_data} :
    h_qctl ? {24'h000000, queue_control_r} :
    h_line ? {24'h000000, line_control_r} :
    h_modem ? {24'h000000, modem_control_r} :
    h_stat ? {24'h000000, status} :
    h_brk ? {31'h00000000, brk} :
    h_dma ? {31'h00000000, dma_mode} :
    h_qen ? {31'h00000000, qen} :
    32'h00000000;

  // Control registers reset to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_control_r <= CTL_RESET;
      modem_control_r <= CTL_RESET;
      queue_control_r <= CTL_RESET;
    end else begin
      line_control_r <= line_control_nxt;
      modem_control_r <= modem_control_nxt;
      queue_control_r <= queue_control_nxt;
    end
  end

  // Bus answer: ready, data and error all come from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= rd_cap;
      pslverr_r <= rd_cap & ~h_any;
      if (rd_cap) begin
        prdata_r <= rd_val;
      end
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_seen_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      break_seen_r <= rx_brk_evt |
        (break_seen_r & ~(wr_done & h_stat & pwdata[ST_BREAK]));
      overrun_r <= (rx_push & ~rx_in_ok) |
        (overrun_r & ~(wr_done & h_stat & pwdata[ST_OVERRUN]));
    end
  end

  // ----------------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------------

  // With queues disabled each side holds a single character.
  assign tx_in_ok = qen ? tx_in_ready : tx_empty;
  assign rx_in_ok = qen ? rx_in_ready : ~rx_valid;
  assign tx_empty = (tx_level == '0);

  queue_buffer #(.WIDTH(CHAR_W), .DEPTH(QUEUE_DEPTH)) send_queue (
    .pclk(pclk),
    .presetn(presetn),
    .flush(tx_flush),
    .in_valid(wr_done & h_data & tx_in_ok),
    .in_ready(tx_in_ready),
    .in_data(pwdata[CHAR_W-1:0]),
    .out_valid(tx_valid),
    .out_ready(tx_pop),
    .out_data(tx_data),
    .level(tx_level)
  );

  queue_buffer #(.WIDTH(CHAR_W), .DEPTH(QUEUE_DEPTH)) receive_queue (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rx_flush),
    .in_valid(rx_push & rx_in_ok),
    .in_ready(rx_in_ready),
    .in_data(rx_shift_r),
    .out_valid(rx_valid),
    .out_ready(rd_done & h_data),
    .out_data(rx_data),
    .level(rx_level)
  );

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------

  ser_type tx_st_r;
  logic [CW-1:0] bcnt_r;
  logic [2:0] tx_idx_r;
  logic [CHAR_W-1:0] tx_shift_r;
  logic tick, ser_bit, tx_line;
  logic sout_r, sir_n_r;

  // Bit timing, serial bit and the break override of the line.
  assign tick = (bcnt_r == CW'(BIT_CYCLES-1));
  assign tx_pop = (tx_st_r == idle_s) & tx_valid & tick;
  assign ser_bit = (tx_st_r == start_s) ? 1'b0 :
                   (tx_st_r == data_s) ? tx_shift_r[0] : 1'b1;
  assign tx_line = brk ? 1'b0 : ser_bit;

  // Frame sequencer: start, eight data bits LSB first, one stop bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_r <= '0;
      tx_st_r <= idle_s;
      tx_idx_r <= 3'h0;
      tx_shift_r <= '0;
    end else begin
      bcnt_r <= tick ? '0 : bcnt_r + 1'b1;
      if (tick) begin
        case (tx_st_r)
          idle_s: if (tx_valid) begin
            tx_shift_r <= tx_data;
            tx_st_r <= start_s;
          end
          start_s: begin
            tx_idx_r <= 3'h0;
            tx_st_r <= data_s;
          end
          data_s: begin
            tx_shift_r <= tx_shift_r >> 1;
            tx_idx_r <= tx_idx_r + 1'b1;
            if (tx_idx_r == 3'h7) begin
              tx_st_r <= stop_s;
            end
          end
          default: tx_st_r <= idle_s;
        endcase
      end
    end
  end

  // Pins: loopback parks the line idle; infrared pulses each low bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sout_r <= 1'b1;
      sir_n_r <= 1'b1;
    end else begin
      sout_r <= loop | tx_line;
      sir_n_r <= ~(ir & ~loop & ~tx_line &
                   (bcnt_r < CW'(IR_PULSE)));
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------

  ser_type rx_st_r;
  logic [CW-1:0] rcnt_r;
  logic [2:0] rx_idx_r;

  // Loopback feeds the internal line, break included, to the receiver.
  assign rx_line = loop ? tx_line : sin;
  assign samp = (rcnt_r == '0) & (rx_st_r != idle_s);
  assign rx_push = samp & (rx_st_r == stop_s) & rx_line;
  assign rx_brk_evt = samp & (rx_st_r == stop_s) & ~rx_line &
                      (rx_shift_r == '0);

  // Mid-bit sampler; a low stop bit after zero data marks a break.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= idle_s;
      rcnt_r <= '0;
      rx_idx_r <= 3'h0;
      rx_shift_r <= '0;
    end else begin
      if (rx_st_r == idle_s) begin
        rcnt_r <= CW'(BIT_CYCLES/2);
      end else begin
        rcnt_r <= samp ? CW'(BIT_CYCLES-1) : rcnt_r - 1'b1;
      end
      case (rx_st_r)
        idle_s: if (!rx_line) begin
          rx_st_r <= start_s;
        end
        start_s: if (samp) begin
          rx_idx_r <= 3'h0;
          rx_st_r <= rx_line ? idle_s : data_s;
        end
        data_s: if (samp) begin
          rx_shift_r <= {rx_line, rx_shift_r[CHAR_W-1:1]};
          rx_idx_r <= rx_idx_r + 1'b1;
          if (rx_idx_r == 3'h7) begin
            rx_st_r <= stop_s;
          end
        end
        stop_s: if (samp) begin
          rx_st_r <= idle_s;
        end
        default: rx_st_r <= idle_s;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // DMA requests
  // ----------------------------------------------------------------------

  logic dtx_n_r, drx_n_r;

  // Mode 0: single requests; mode 1: burst requests by level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtx_n_r <= 1'b1;
      drx_n_r <= 1'b1;
    end else begin
      dtx_n_r <= dma_mode ? ~tx_in_ok : ~tx_empty;
      drx_n_r <= dma_mode ? ~(rx_level >= LW'(RX_BURST))
                          : ~rx_valid;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sout = sout_r;
  assign sir_out_n = sir_n_r;
  assign dma_tx_req_n = dtx_n_r;
  assign dma_rx_req_n = drx_n_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  localparam int IR_WIN = 64;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_brk_alias;
    wr_done & h_brk |=> brk == $past(pwdata[0]) &&
      (line_control_r & ~BRK_MASK) == ($past(line_control_r) & ~BRK_MASK);
  endproperty
  a_brk_alias: assert property (p_brk_alias)
    else $error("break alias write disturbed line control");

  property p_brk_low;
    brk && !loop |=> !sout;
  endproperty
  a_brk_low: assert property (p_brk_low)
    else $error("serial output not low during break");

  property p_ir_pulse;
    (ir && brk && !loop)[*2] |->
      ##[0:IR_WIN] !sir_out_n ##[1:IR_WIN] sir_out_n;
  endproperty
  a_ir_pulse: assert property (p_ir_pulse)
    else $error("infrared output not pulsing during break");

  property p_loop_idle;
    loop |-> (!brk || !rx_line) ##1 sout;
  endproperty
  a_loop_idle: assert property (p_loop_idle)
    else $error("loopback break reached the pin or missed receiver");

  property p_dma_alias;
    wr_done & h_dma |=> dma_mode == $past(pwdata[0]) &&
      (queue_control_r & ~DMA_MASK) == ($past(queue_control_r) & ~DMA_MASK);
  endproperty
  a_dma_alias: assert property (p_dma_alias)
    else $error("dma alias write disturbed queue control");

  property p_dma_mode0;
    !dma_mode && !tx_empty |=> dma_tx_req_n;
  endproperty
  a_dma_mode0: assert property (p_dma_mode0)
    else $error("mode 0 transmit request with data queued");

  property p_qen_alias;
    wr_done & h_qen |=> qen == $past(pwdata[0]) &&
      (queue_control_r & ~QEN_MASK) == ($past(queue_control_r) & ~QEN_MASK);
  endproperty
  a_qen_alias: assert property (p_qen_alias)
    else $error("enable alias write disturbed queue control");

  property p_qen_flush;
    $fell(qen) |-> tx_empty && !rx_valid;
  endproperty
  a_qen_flush: assert property (p_qen_flush)
    else $error("queues not emptied when disabled");

  property p_alias_zero;
    rd_done && (h_brk || h_dma || h_qen || h_rtrig) |-> prdata[31:1] == 0;
  endproperty
  a_alias_zero: assert property (p_alias_zero)
    else $error("alias upper bits not zero");

  c_break: cover property (brk && !loop ##1 !sout);
  c_ir: cover property (ir && brk ##1 !sir_out_n);
  c_flush: cover property ($fell(qen) && !$past(tx_empty));
  c_rx_char: cover property (rx_push && loop);

endmodule : uart_shadow_control

// file: tb/serial_far_end.sv
// Remote serial device model that sends on sin and logs frames from sout.
`timescale 1ns/1ps
module serial_far_end #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic sout,
  output logic sin
);
  logic [7:0] got [0:15];
  logic [7:0] shift;
  int got_n;

  // Sends one 8N1 frame, then leaves the line idle high for gap cycles.
  task automatic send(input logic [7:0] ch, input int gap);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sin <= frame[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
    repeat (gap) @(posedge pclk);
  endtask : send

  // Logs frames with a high stop bit; a line held low is skipped over.
  initial begin
    sin = 1'b1;
    got_n = 0;
    forever begin
      @(posedge pclk);
      if (sout === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge pclk);
          shift[i] = sout;
        end
        repeat (BIT_CYCLES) @(posedge pclk);
        if (sout === 1'b1) begin
          got[got_n[3:0]] = shift;
          got_n++;
        end
        while (sout !== 1'b1) @(posedge pclk);
      end
    end
  end
endmodule : serial_far_end

// file: tb/uart_shadow_control_bench.sv
// Self-checking bench for the serial port shadow control bits.
`timescale 1ns/1ps
`define CMP(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %0h, expected %0h", $time, \
        (got), (exp)); \
    end \
  end
module uart_shadow_control_bench
  import shadow_pkg::*;
;
  localparam int BITC = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sin, sout, sir_out_n, dma_tx_req_n, dma_rx_req_n, re;
  logic [31:0] paddr, pwdata, prdata, rv;
  int mismatches = 0;
  int checks_done = 0;
  int cnt;
  int base;

  uart_shadow_control #(.BIT_CYCLES(BITC)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sin(sin), .sout(sout),
    .sir_out_n(sir_out_n), .dma_tx_req_n(dma_tx_req_n),
    .dma_rx_req_n(dma_rx_req_n)
  );
  serial_far_end #(.BIT_CYCLES(BITC)) far (
    .pclk(pclk), .sout(sout), .sin(sin)
  );

  // Free-running 40 MHz bus clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // One APB transfer; read data and error flag are kept in rv and re.
  task automatic acc(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CMP(pready, 1'b1)
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : acc

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    acc(1'b0, a, 32'h0);
  endtask : rd

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Aliases, break, infrared, loopback, queue fill and drain, DMA modes.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_BREAK_ALIAS + 32'(4 * i));
      `CMP(rv, 32'h0)
    end
    rd(32'h50001104);
    `CMP(re, 1'b1)
    wr(ADDR_QUEUE_CTL, 32'h50);
    wr(ADDR_DMA_ALIAS, 32'hffffffff);
    rd(ADDR_QUEUE_CTL);
    `CMP(rv, 32'h58)
    rd(ADDR_DMA_ALIAS);
    `CMP(rv, 32'h1)
    wr(ADDR_QEN_ALIAS, 32'hffffffff);
    rd(ADDR_QUEUE_CTL);
    `CMP(rv, 32'h59)
    wr(ADDR_RXTRIG_ALIAS, 32'hffffffff);
    rd(ADDR_RXTRIG_ALIAS);
    `CMP(rv, 32'h0)
    wr(ADDR_LINE_CTL, 32'h40);
    rd(ADDR_BREAK_ALIAS);
    `CMP(rv, 32'h1)
    for (int i = 0; i < 60; i++) begin
      @(posedge pclk);
      `CMP(sout, 1'b0)
    end
    wr(ADDR_BREAK_ALIAS, 32'h0);
    rd(ADDR_LINE_CTL);
    `CMP(rv & 32'(BRK_MASK), 32'h0)
    `CMP(sout, 1'b1)
    wr(ADDR_MODEM_CTL, 32'h40);
    wr(ADDR_BREAK_ALIAS, 32'h1);
    repeat (8) @(posedge pclk);
    cnt = 0;
    for (int i = 0; i < 10 * BITC; i++) begin
      @(posedge pclk);
      if (sir_out_n === 1'b0) cnt++;
    end
    `CMP(cnt, 10 * IR_PULSE_DEF)
    wr(ADDR_BREAK_ALIAS, 32'h0);
    wr(ADDR_MODEM_CTL, 32'h10);
    wr(ADDR_BREAK_ALIAS, 32'h1);
    for (int i = 0; i < 60; i++) begin
      @(posedge pclk);
      `CMP(sout, 1'b1)
    end
    wr(ADDR_BREAK_ALIAS, 32'h0);
    rd(ADDR_STATUS);
    `CMP(rv[ST_BREAK], 1'b1)
    wr(ADDR_MODEM_CTL, 32'h0);
    repeat (12 * BITC) @(posedge pclk);
    // Write nine characters so that the send queue reports full, then let it drain.
    base = far.got_n;
    for (int i = 0; i < 9; i++) wr(ADDR_DATA, 32'h30 + 32'(i));
    rd(ADDR_STATUS);
    `CMP(rv[ST_TXFULL], 1'b1)
    `CMP(dma_tx_req_n, 1'b1)
    cnt = 0;
    do begin
      rd(ADDR_STATUS);
      cnt++;
    end while (rv[ST_TXEMPTY] !== 1'b1 && cnt < 200);
    repeat (12 * BITC) @(posedge pclk);
    `CMP(far.got_n, base + 9)
    for (int i = 0; i < 9; i++) begin
      `CMP(far.got[base + i], 8'h30 + 8'(i))
    end
    // Receive queue level against both DMA signalling modes.
    wr(ADDR_QUEUE_CTL, 32'h5b);
    for (int i = 0; i < 3; i++) far.send(8'ha5 + 8'(i), i);
    repeat (3 * BITC) @(posedge pclk);
    `CMP(dma_rx_req_n, 1'b1)
    far.send(8'ha8, 0);
    repeat (3 * BITC) @(posedge pclk);
    `CMP(dma_rx_req_n, 1'b0)
    rd(ADDR_DATA);
    `CMP(rv, 32'ha5)
    // The request flop follows the level one edge after the pop.
    repeat (2) @(posedge pclk);
    `CMP(dma_rx_req_n, 1'b1)
    wr(ADDR_DMA_ALIAS, 32'h0);
    repeat (2) @(posedge pclk);
    `CMP(dma_rx_req_n, 1'b0)
    `CMP(dma_tx_req_n, 1'b0)
    // Leave one character queued so that disabling must flush it.
    wr(ADDR_DATA, 32'h3a);
    wr(ADDR_DATA, 32'h3b);
    repeat (2) @(posedge pclk);
    `CMP(dma_tx_req_n, 1'b1)
    wr(ADDR_QEN_ALIAS, 32'h0);
    repeat (2) @(posedge pclk);
    `CMP(dma_rx_req_n, 1'b1)
    rd(ADDR_STATUS);
    `CMP(rv[2:1], 2'b01)
    rd(ADDR_QUEUE_CTL);
    `CMP(rv, 32'h50)
    close_out();
  end
endmodule : uart_shadow_control_bench
